/* File: rtl/pic_host_defines.vh */
// constants for the host-side controller of a cascaded interrupt controller
`ifndef PIC_HOST_DEFINES_VH
`define PIC_HOST_DEFINES_VH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define REG_CMD 8'h00
`define REG_SEQ 8'h04
`define REG_STATUS 8'h08
`define REG_CTRL 8'h0C

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CMD_A0 8
`define CMD_SLAVE 9
`define CMD_MAP_CHECK 10
`define CMD_READ 11
`define SEQ_EXC_ENTRY 0
`define SEQ_CASC_EOI 1
`define SEQ_SPEC_EOI 2
`define SEQ_SLAVE 7
`define STAT_BUSY 0
`define STAT_INT 1
`define STAT_REFUSED 2
`define CTRL_AUTO_ACK 0
`define CTRL_THREE_ACK 1
`define CTRL_RESET 2'h0

// ----------------------------------------------------------------------------
// command words sent to the device
// ----------------------------------------------------------------------------
`define MODE_READ_SVC 8'h0B
`define MODE_EXC_SET 8'h68
`define FINISH_NORMAL 8'h20
`define FINISH_SPECIFIC 8'h60

// ----------------------------------------------------------------------------
// pin cycle kinds and timing
// ----------------------------------------------------------------------------
`define OP_WRITE 2'h0
`define OP_READ 2'h1
`define OP_ACK 2'h2
`define CLK_NS 10
`define STROBE_NS 100
`define RECOVER_NS 100
`define STROBE_CYC ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define RECOVER_CYC ((`RECOVER_NS + `CLK_NS - 1) / `CLK_NS)

`endif

/* File: rtl/dev_bus_cycle.v */
// one read, write or acknowledge cycle on the device's pins
`include "pic_host_defines.vh"

module dev_bus_cycle (
  input wire hclk,
  input wire hresetn,
  input wire start,
  input wire [1:0] op,
  input wire a0,
  input wire sel_slave,
  input wire [7:0] wdata,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg data_oe,
  output reg addr0,
  output reg master_cs_n,
  output reg slave_cs_n,
  output reg wr_n,
  output reg rd_n,
  output reg ack_strobe_n,
  output reg done,
  output reg [7:0] rdata
);
  localparam IDLE = 2'h0;
  localparam SETUP = 2'h1;
  localparam STROBE = 2'h2;
  localparam RECOVER = 2'h3;

  reg [1:0] state;
  reg [7:0] cnt;
  reg [1:0] cur_op;
  reg [7:0] din_meta;
  reg [7:0] din_sync;

  // device data pins arrive unclocked
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      din_meta <= 8'h00;
      din_sync <= 8'h00;
    end else begin
      din_meta <= data_in;
      din_sync <= din_meta;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= IDLE;
      cnt <= 8'h00;
      cur_op <= `OP_WRITE;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      addr0 <= 1'b0;
      master_cs_n <= 1'b1;
      slave_cs_n <= 1'b1;
      wr_n <= 1'b1;
      rd_n <= 1'b1;
      ack_strobe_n <= 1'b1;
      done <= 1'b0;
      rdata <= 8'h00;
    end else begin
      done <= 1'b0;
      case (state)
        IDLE: begin
          if (start) begin
            cur_op <= op;
            addr0 <= a0;
            data_out <= wdata;
            // acknowledge cycles never drive the data bus
            data_oe <= (op == `OP_WRITE);
            master_cs_n <= (op == `OP_ACK) | sel_slave;
            slave_cs_n <= (op == `OP_ACK) | ~sel_slave;
            state <= SETUP;
          end
        end
        SETUP: begin
          wr_n <= ~(cur_op == `OP_WRITE);
          rd_n <= ~(cur_op == `OP_READ);
          ack_strobe_n <= ~(cur_op == `OP_ACK);
          cnt <= 8'h00;
          state <= STROBE;
        end
        STROBE: begin
          cnt <= cnt + 8'h01;
          if (cnt == (`STROBE_CYC - 1)) begin
            // two-flop delay is well inside the strobe width
            rdata <= din_sync;
            wr_n <= 1'b1;
            rd_n <= 1'b1;
            ack_strobe_n <= 1'b1;
            cnt <= 8'h00;
            state <= RECOVER;
          end
        end
        RECOVER: begin
          data_oe <= 1'b0;
          master_cs_n <= 1'b1;
          slave_cs_n <= 1'b1;
          cnt <= cnt + 8'h01;
          if (cnt == (`RECOVER_CYC - 1)) begin
            done <= 1'b1;
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end
endmodule // dev_bus_cycle

/* File: rtl/pic_host_ctrl.v */
// host controller: AHB-Lite registers driving a master and a slave device
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`include "pic_host_defines.vh"

module pic_host_ctrl (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  input wire dev_int,
  input wire [7:0] data_in,
  output wire [7:0] data_out,
  output wire data_oe,
  output wire addr0,
  output wire master_cs_n,
  output wire slave_cs_n,
  output wire wr_n,
  output wire rd_n,
  output wire ack_strobe_n
);
  // --------------------------------------------------------------------------
  // sequence steps
  // --------------------------------------------------------------------------
  localparam S_IDLE = 4'h0;
  localparam S_CMD = 4'h1;
  localparam S_ACK = 4'h2;
  localparam S_EX_SEL = 4'h3;
  localparam S_EX_READ = 4'h4;
  localparam S_EX_MASK = 4'h5;
  localparam S_EX_MODE = 4'h6;
  localparam S_CE_SLV = 4'h7;
  localparam S_CE_SEL = 4'h8;
  localparam S_CE_READ = 4'h9;
  localparam S_CE_MST = 4'hA;
  localparam S_SPEC = 4'hB;

  reg [3:0] step;
  reg waiting;
  reg start;
  reg [11:0] cmd;
  reg [7:0] seq;
  reg [7:0] isr_copy;
  reg [7:0] last_read;
  reg [7:0] vector;
  reg [1:0] ack_left;
  reg [1:0] ctrl;
  reg refused;
  reg int_meta;
  reg int_sync;
  reg ph_write;
  reg [7:0] ph_addr;
  reg [1:0] op;
  reg a0;
  reg sel_slave;
  reg [7:0] wdata;
  wire done;
  wire [7:0] rdata;
  wire busy = (step != S_IDLE);

  // --------------------------------------------------------------------------
  // interrupt line synchroniser
  // --------------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_meta <= 1'b0;
      int_sync <= 1'b0;
    end else begin
      int_meta <= dev_int;
      int_sync <= int_meta;
    end
  end

  // --------------------------------------------------------------------------
  // what each step puts on the pins
  // --------------------------------------------------------------------------
  always @* begin
    op = `OP_WRITE;
    a0 = 1'b0;
    sel_slave = 1'b0;
    wdata = 8'h00;
    case (step)
      S_CMD: begin
        op = cmd[`CMD_READ] ? `OP_READ : `OP_WRITE;
        a0 = cmd[`CMD_A0];
        sel_slave = cmd[`CMD_SLAVE];
        wdata = cmd[7:0];
      end
      S_ACK: op = `OP_ACK;
      S_EX_SEL: begin
        sel_slave = seq[`SEQ_SLAVE];
        wdata = `MODE_READ_SVC;
      end
      S_EX_READ: begin
        op = `OP_READ;
        sel_slave = seq[`SEQ_SLAVE];
      end
      S_EX_MASK: begin
        a0 = 1'b1;
        sel_slave = seq[`SEQ_SLAVE];
        wdata = isr_copy;
      end
      S_EX_MODE: begin
        sel_slave = seq[`SEQ_SLAVE];
        wdata = `MODE_EXC_SET;
      end
      S_CE_SLV: begin
        sel_slave = 1'b1;
        wdata = `FINISH_NORMAL;
      end
      S_CE_SEL: begin
        sel_slave = 1'b1;
        wdata = `MODE_READ_SVC;
      end
      S_CE_READ: begin
        op = `OP_READ;
        sel_slave = 1'b1;
      end
      S_CE_MST: wdata = `FINISH_NORMAL;
      S_SPEC: begin
        sel_slave = seq[`SEQ_SLAVE];
        wdata = `FINISH_SPECIFIC | {5'h00, seq[6:4]};
      end
      default: op = `OP_WRITE;
    endcase
  end

  // --------------------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // --------------------------------------------------------------------------
  wire take = hsel & hready & htrans[1];
  wire wr_cmd = ph_write & (ph_addr == `REG_CMD);
  wire wr_seq = ph_write & (ph_addr == `REG_SEQ);
  wire wr_stat = ph_write & (ph_addr == `REG_STATUS);
  // address zero for a slave is only safe when all eight are fitted
  wire bad_slave_map = hwdata[`CMD_MAP_CHECK] & hwdata[0] &
                 (hwdata[7:0] != 8'hFF);
  wire cmd_ok = wr_cmd & ~busy & ~bad_slave_map;
  wire seq_ok = wr_seq & ~busy & (hwdata[2:0] != 3'h0);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      ctrl <= `CTRL_RESET;
      refused <= 1'b0;
    end else begin
      ph_write <= take & hwrite;
      ph_addr <= haddr;
      if (take & ~hwrite) begin
        case (haddr)
          `REG_STATUS: hrdata <= {5'h00, 3'h0, vector, last_read,
                                  5'h00, refused, int_sync, busy};
          `REG_CTRL: hrdata <= {30'h00000000, ctrl};
          default: hrdata <= 32'h00000000;
        endcase
      end
      if (ph_write & (ph_addr == `REG_CTRL))
        ctrl <= hwdata[1:0];
      // a refusal in the same cycle as its clear still wins
      if ((wr_cmd & ~cmd_ok) | (wr_seq & busy))
        refused <= 1'b1;
      else if (wr_stat & hwdata[`STAT_REFUSED])
        refused <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step <= S_IDLE;
      waiting <= 1'b0;
      start <= 1'b0;
      cmd <= 12'h000;
      seq <= 8'h00;
      isr_copy <= 8'h00;
      last_read <= 8'h00;
      vector <= 8'h00;
      ack_left <= 2'h0;
    end else begin
      start <= 1'b0;
      if (step == S_IDLE) begin
        if (cmd_ok) begin
          cmd <= hwdata[11:0];
          step <= S_CMD;
        end else if (seq_ok) begin
          seq <= hwdata[7:0];
          if (hwdata[`SEQ_EXC_ENTRY])
            step <= S_EX_SEL;
          else if (hwdata[`SEQ_CASC_EOI])
            step <= S_CE_SLV;
          else
            step <= S_SPEC;
        end else if (int_sync & ctrl[`CTRL_AUTO_ACK]) begin
          // the selected slave answers the later strobes itself
          ack_left <= ctrl[`CTRL_THREE_ACK] ? 2'h2 : 2'h1;
          step <= S_ACK;
        end
      end else if (!waiting) begin
        start <= 1'b1;
        waiting <= 1'b1;
      end else if (done) begin
        waiting <= 1'b0;
        case (step)
          S_CMD: begin
            if (cmd[`CMD_READ])
              last_read <= rdata;
            step <= S_IDLE;
          end
          S_ACK: begin
            // final byte holds the vector; its low bits name the input
            vector <= rdata;
            ack_left <= ack_left - 2'h1;
            if (ack_left == 2'h0)
              step <= S_IDLE;
          end
          S_EX_SEL: step <= S_EX_READ;
          S_EX_READ: begin
            isr_copy <= rdata;
            last_read <= rdata;
            step <= S_EX_MASK;
          end
          S_EX_MASK: step <= S_EX_MODE;
          S_CE_SLV: step <= S_CE_SEL;
          S_CE_SEL: step <= S_CE_READ;
          S_CE_READ: begin
            last_read <= rdata;
            // master is finished only once the slave is fully idle
            step <= (rdata == 8'h00) ? S_CE_MST : S_IDLE;
          end
          default: step <= S_IDLE;
        endcase
      end
    end
  end

  dev_bus_cycle u_cycle (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(start),
    .op(op),
    .a0(a0),
    .sel_slave(sel_slave),
    .wdata(wdata),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe(data_oe),
    .addr0(addr0),
    .master_cs_n(master_cs_n),
    .slave_cs_n(slave_cs_n),
    .wr_n(wr_n),
    .rd_n(rd_n),
    .ack_strobe_n(ack_strobe_n),
    .done(done),
    .rdata(rdata)
  );
endmodule // pic_host_ctrl

/* File: verif/pic_host_checker.sv */
// pin and bus assertions for the host interrupt controller driver
module pic_host_checker (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire [7:0] data_out,
  input wire data_oe,
  input wire master_cs_n,
  input wire slave_cs_n,
  input wire wr_n,
  input wire rd_n,
  input wire ack_strobe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  bus_ready_a: assert property (hreadyout && !hresp)
    else $error("bus stalled or error");
  wr_width_a: assert property ($fell(wr_n) |=> !wr_n[*8] ##1 !wr_n ##1 wr_n)
    else $error("write strobe width");
  rd_width_a: assert property ($fell(rd_n) |-> !rd_n[*8] ##1 !rd_n[*2] ##1 rd_n)
    else $error("read strobe width");
  one_strobe_a: assert property (wr_n || (rd_n && ack_strobe_n))
    else $error("strobes overlap");
  ack_no_data_a: assert property (!ack_strobe_n |->
    master_cs_n && slave_cs_n && !data_oe)
    else $error("ack with select or drive");
  one_select_a: assert property (!(wr_n && rd_n) |-> master_cs_n != slave_cs_n)
    else $error("select wrong in strobe");
  wr_data_a: assert property (!wr_n |-> data_oe && $stable(data_out))
    else $error("write data moved");
  rd_float_a: assert property (!rd_n |-> !data_oe)
    else $error("drive during read");
  recover_a: assert property ($rose(wr_n) |=> (wr_n && rd_n && ack_strobe_n)[*8])
    else $error("recovery too short");
endmodule // pic_host_checker

/* File: verif/pic_dev_model.sv */
// behavioural master and slave interrupt controllers on the host pins
module pic_dev_model #(
  parameter logic [7:0] VEC_BASE = 8'h40
) (
  input wire master_cs_n,
  input wire slave_cs_n,
  input wire wr_n,
  input wire rd_n,
  input wire ack_strobe_n,
  input wire addr0,
  input wire [7:0] data_out,
  input wire req_on,
  input wire [2:0] req_level,
  output wire dev_int,
  output wire [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] isr_m = 0, isr_s = 0, mask_m = 0, last_wr = 0, last = 0, val;
  logic exc_mode_m = 0, sel_isr = 0, acked = 0, rd_slave = 0;
  int acks = 0, writes = 0;
  wire [7:0] higher = (8'h01 << req_level) - 8'h01;
  // level 0 ranks highest, so the lowest set bit is finished first
  assign dev_int = req_on && !acked && (exc_mode_m ? !mask_m[req_level]
    : !(isr_m & higher));
  always @(negedge wr_n) begin
    writes++;
    last_wr = data_out;
    if (addr0) mask_m = data_out;
    else if (data_out[4:3] == 2'b01) begin
      if (data_out[1]) sel_isr = data_out[0];
      if (data_out[6]) exc_mode_m = data_out[5];
    end else if (data_out[7:3] == 5'b00100) begin
      if (master_cs_n) isr_s = isr_s & (isr_s - 8'h01);
      else isr_m = isr_m & (isr_m - 8'h01);
    end else if (data_out[7:3] == 5'b01100) begin
      if (master_cs_n) isr_s[data_out[2:0]] = 1'b0;
      else isr_m[data_out[2:0]] = 1'b0;
    end
  end
  always @(negedge rd_n) rd_slave = master_cs_n;
  always @(negedge ack_strobe_n or negedge req_on) begin
    if (!req_on) acked = 0;
    else begin
      acks++;
      acked = 1;
      isr_m[req_level] = 1'b1;
    end
  end
  always @* begin
    if (!ack_strobe_n) val = VEC_BASE | {5'h00, req_level};
    else if (addr0) val = mask_m;
    else if (!sel_isr) val = 8'h00;
    else val = rd_slave ? isr_s : isr_m;
  end
  // released bus shows the inverse so a stale byte cannot pass
  always @(posedge rd_n or posedge ack_strobe_n) last = val;
  assign data_in = (!rd_n || !ack_strobe_n) ? val : ~last;
endmodule // pic_dev_model

/* File: verif/testbench.sv */
// self-checking bench for the host interrupt controller driver
`include "pic_host_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, req_on = 0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, req_level = 3'h0;
  logic [31:0] hwdata = 32'h0, rd;
  wire hreadyout, hresp, dev_int, data_oe, addr0, master_cs_n, slave_cs_n;
  wire wr_n, rd_n, ack_strobe_n;
  wire [31:0] hrdata;
  wire [7:0] data_in, data_out;
  int bad_count = 0, checks = 0;
  always #5 hclk = ~hclk;
  pic_host_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .dev_int(dev_int), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .addr0(addr0),
    .master_cs_n(master_cs_n), .slave_cs_n(slave_cs_n), .wr_n(wr_n),
    .rd_n(rd_n), .ack_strobe_n(ack_strobe_n));
  pic_dev_model dev (.master_cs_n(master_cs_n), .slave_cs_n(slave_cs_n),
    .wr_n(wr_n), .rd_n(rd_n), .ack_strobe_n(ack_strobe_n), .addr0(addr0),
    .data_out(data_out), .req_on(req_on), .req_level(req_level),
    .dev_int(dev_int), .data_in(data_in));
  task end_sim;
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp, input string s);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    rd = hrdata;
  endtask
  task wait_idle;
    rd = 1;
    for (int i = 0; i < 300 && rd[0] !== 1'b0; i++) ahb(0, `REG_STATUS, 0);
  endtask
  task t_regs;
    ahb(0, `REG_CTRL, 0);
    cmp(rd, 0, "ctrl reset");
    ahb(1, `REG_CTRL, 3);
    ahb(0, `REG_CTRL, 0);
    cmp(rd[1:0], 3, "ctrl rw");
    ahb(1, `REG_CTRL, 0);
    ahb(0, 8'h40, 0);
    cmp(32'(hresp), 0, "unmapped response");
  endtask
  task t_spec;
    dev.isr_m = 8'h24;
    dev.isr_s = 8'h20;
    ahb(1, `REG_SEQ, 32'h54);
    wait_idle;
    cmp(dev.isr_m, 8'h04, "master specific end");
    cmp(dev.last_wr, 8'h65, "specific end byte");
    ahb(1, `REG_SEQ, 32'hD4);
    wait_idle;
    cmp(dev.isr_s, 8'h00, "slave specific end");
  endtask
  task t_exceptional_nesting_bit;
    dev.isr_m = 8'h24;
    dev.mask_m = 8'h00;
    ahb(1, `REG_SEQ, 1);
    wait_idle;
    cmp(dev.mask_m, 8'h24, "mask copy");
    cmp(dev.exc_mode_m, 1, "exceptional set");
  endtask
  task t_casc;
    for (int i = 0; i < 2; i++) begin
      dev.isr_s = i ? 8'h03 : 8'h01;
      dev.isr_m = 8'h80;
      ahb(1, `REG_SEQ, 2);
      wait_idle;
      cmp(dev.isr_s, i ? 8'h02 : 8'h00, "slave end first");
      cmp(dev.isr_m, i ? 8'h80 : 8'h00, "master end gated");
    end
  endtask
  task t_refuse;
    ahb(1, `REG_CMD, 32'h401);
    ahb(0, `REG_STATUS, 0);
    cmp(rd[2], 1, "zero address refused");
    ahb(1, `REG_STATUS, 4);
    ahb(0, `REG_STATUS, 0);
    cmp(rd[2], 0, "refusal cleared");
    dev.writes = 0;
    ahb(1, `REG_CMD, 32'h5FF);
    wait_idle;
    cmp(dev.writes, 1, "full slave map sent");
    cmp(dev.last_wr, 8'hFF, "init word three byte");
  endtask
  task t_ack;
    dev.exc_mode_m = 0;
    for (int n = 1; n < 4; n += 2) begin
      dev.isr_m = 8'h00;
      dev.acks = 0;
      ahb(1, `REG_CTRL, n);
      req_level <= 3'(n + 2);
      req_on <= 1'b1;
      // two strobes when the three-ack bit is clear, three when set
      for (int i = 0; i < 300 && (dev.acks < (n > 1 ? 3 : 2) || rd[0]); i++)
        ahb(0, `REG_STATUS, 0);
      cmp(rd[23:16], 8'h40 | (n + 2), "vector stored");
      cmp(dev.acks, (n > 1 ? 3 : 2), "ack count");
      req_on <= 1'b0;
      ahb(1, `REG_CTRL, 0);
    end
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_spec;
    t_exceptional_nesting_bit;
    t_casc;
    t_refuse;
    t_ack;
    end_sim;
  end
  initial begin
    #300000;
    bad_count++;
    end_sim;
  end
endmodule // testbench
bind pic_host_ctrl pic_host_checker chk (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .data_out(data_out),
  .data_oe(data_oe), .master_cs_n(master_cs_n), .slave_cs_n(slave_cs_n),
  .wr_n(wr_n), .rd_n(rd_n), .ack_strobe_n(ack_strobe_n));
